/* File: inc/sfl_consts.svh */
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH

// Command codes.
`define SFL_CMD_WRITE_LATCH_SET 8'h06
`define SFL_CMD_WRITE_LATCH_CLR 8'h04
`define SFL_CMD_STATUS_READ     8'h05
`define SFL_CMD_STATUS_WRITE    8'h01
`define SFL_CMD_READ            8'h03
`define SFL_CMD_DUAL_OUT_READ   8'h3B
`define SFL_CMD_DUAL_IO_READ    8'hBB
`define SFL_CMD_PAGE_WRITE      8'h02
`define SFL_CMD_FOUR_KB_WIPE    8'h20
`define SFL_CMD_BLOCK_WIPE      8'hD8
`define SFL_CMD_CHIP_WIPE       8'hC7

// Byte positions inside a frame, counted from the command byte at 0.
`define SFL_IDX_CMD       4'h0
`define SFL_IDX_ARG       4'h1
`define SFL_IDX_ADDR_END  4'h3
`define SFL_IDX_DATA      4'h4
`define SFL_IDX_DUAL_DATA 4'h5
`define SFL_IDX_MAX       4'hF

// Array geometry.
`define SFL_ADDR_W       18
`define SFL_PAGE_BITS    8
`define SFL_SECTOR_BITS  12
`define SFL_BLOCK_BITS   16
`define SFL_ERASED_BYTE  8'hFF

// Internal cycle times.
`define SFL_CLK_MHZ        25
`define SFL_T_PAGE_US      1500
`define SFL_T_FOUR_KB_US   150000
`define SFL_T_BLOCK_US     800000
`define SFL_T_CHIP_US      3200000
`define SFL_STATUS_WR_CYC  100

// Controller registers and fields.
`define SFL_REG_XFER   4'h0
`define SFL_REG_CFG    4'h4
`define SFL_XF_RX      8
`define SFL_XF_DUAL    9
`define SFL_XF_LAST    10
`define SFL_CFG_CPOL   0
`define SFL_CFG_HOLD   1
`define SFL_CFG_WP     2
`define SFL_CFG_RESET  3'h6
`define SFL_HOST_HALF  4

`endif

/* File: inc/sfl_pkg.sv */
`default_nettype none
package sfl_pkg;
  typedef enum logic [2:0] {
    SFL_H_IDLE = 3'b001,
    SFL_H_LOW  = 3'b010,
    SFL_H_HIGH = 3'b100
  } sfl_hst_t;
endpackage
`default_nettype wire

/* File: inc/sfl_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sfl_if;
  logic sel_n;
  logic sclk;
  logic hold_n;
  logic wp_n;
  logic host_d0_o;
  logic host_d0_oe;
  logic host_d1_o;
  logic host_d1_oe;
  logic dev_d0_o;
  logic dev_d0_oe;
  logic dev_d1_o;
  logic dev_d1_oe;
  wire logic d0;
  wire logic d1;

  // Undriven data lines float high through the board pull-ups.
  assign d0 = host_d0_oe ? host_d0_o : (dev_d0_oe ? dev_d0_o : 1'b1);
  assign d1 = host_d1_oe ? host_d1_o : (dev_d1_oe ? dev_d1_o : 1'b1);

  modport dev (
    input  sel_n, sclk, hold_n, wp_n, d0, d1,
    output dev_d0_o, dev_d0_oe, dev_d1_o, dev_d1_oe
  );
  modport host (
    output sel_n, sclk, hold_n, wp_n, host_d0_o, host_d0_oe, host_d1_o, host_d1_oe,
    input  d0, d1
  );
endinterface
`default_nettype wire

/* File: src/sfl_device.sv */
// Contract
// - Output bits change after serial clock falls.
// - Input bits captured on serial clock rise.
// - Deselected means output line released.
// - Standby only when deselected and idle.
// - Master gives select falling edge first.
// - Pause keeps the partial sequence intact.
// - Paused: outputs released, clock and data ignored.
// - Master selects device before pausing.
// - Write protect freezes protect level bits.
// - Dual reads turn both lines around.
// - Only clock modes 0 and 3.
// - Master parks clock; either level accepted.
// - Write latch set, then page write sequence.
// - Page write: up to 256 bytes, wraps.
// - Program clears bits; erase sets ones.
// - Sector, block and chip wipes exist.
// - Write latch set precedes every wipe.
// - Busy flag set during internal cycles.
// - Four blocks, sixteen sectors, sixteen pages.
// - Write commands need whole-byte clock counts.
// - Write latch clears on write commands.
// - Pause changes only while clock low.
// - Deselect while paused resets interface.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sfl_consts.svh"
module sfl_device #(
  parameter int unsigned ADDR_W    = `SFL_ADDR_W,
  parameter int unsigned PAGE_CYC  = `SFL_T_PAGE_US * `SFL_CLK_MHZ,
  parameter int unsigned SECT_CYC  = `SFL_T_FOUR_KB_US * `SFL_CLK_MHZ,
  parameter int unsigned BLOCK_CYC = `SFL_T_BLOCK_US * `SFL_CLK_MHZ,
  parameter int unsigned CHIP_CYC  = `SFL_T_CHIP_US * `SFL_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Serial link.
  sfl_if.dev              link,
  // Local status.
  output logic            busy_o,
  output logic            standby_o,
  output logic [2:0]      protect_o
);
  localparam int unsigned PAGE_N = 1 << `SFL_PAGE_BITS;
  localparam logic [ADDR_W:0] SZ_PAGE  = (ADDR_W+1)'(1) << `SFL_PAGE_BITS;
  localparam logic [ADDR_W:0] SZ_SECT  = (ADDR_W+1)'(1) << `SFL_SECTOR_BITS;
  localparam logic [ADDR_W:0] SZ_BLOCK = (ADDR_W+1)'(1) << `SFL_BLOCK_BITS;
  localparam logic [ADDR_W:0] SZ_CHIP  = (ADDR_W+1)'(1) << ADDR_W;

  logic [7:0]        mem [0:(1<<ADDR_W)-1];
  logic [7:0]        page_buf [0:PAGE_N-1];
  logic [5:0]        meta_reg;
  logic [5:0]        sync_reg;
  logic              sck_d_reg;
  logic              sel_d_reg;
  logic              armed_reg;
  logic              pause_reg;
  logic [2:0]        bit_reg;
  logic [3:0]        idx_reg;
  logic [7:0]        cmd_reg;
  logic [7:0]        rx_reg;
  logic [7:0]        tx_reg;
  logic [2:0]        stw_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              d0_reg;
  logic              d1_reg;
  logic              oe_reg;
  logic              oe_dual_reg;
  logic              wel_reg;
  logic [2:0]        bp_reg;
  logic [31:0]       timer_reg;
  logic [ADDR_W:0]   left_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic              prog_reg;
  logic [PAGE_N-1:0] pvalid_reg;

  // Input synchronisers; only the second stage is used.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 6'h3F;
      sync_reg <= 6'h3F;
    end else begin
      meta_reg <= {link.sel_n, link.sclk, link.d0, link.d1, link.hold_n, link.wp_n};
      sync_reg <= meta_reg;
    end
  end

  wire sel_s  = sync_reg[5];
  wire sck_s  = sync_reg[4];
  wire d0_s   = sync_reg[3];
  wire d1_s   = sync_reg[2];
  wire hold_s = sync_reg[1];
  wire wp_s   = sync_reg[0];

  // Frames count only once the select line has really fallen.
  wire live     = ~sel_s & armed_reg & ~pause_reg;
  wire rise     = live & sck_s & ~sck_d_reg;
  wire fall     = live & ~sck_s & sck_d_reg;
  wire sel_rise = sel_s & ~sel_d_reg & armed_reg;
  wire busy_w   = (timer_reg != 32'h0) | (left_reg != '0);

  function automatic logic out_phase(input logic [7:0] c, input logic [3:0] i);
    return (c == `SFL_CMD_READ && i >= `SFL_IDX_DATA) ||
           (c == `SFL_CMD_STATUS_READ && i >= `SFL_IDX_ARG) ||
           ((c == `SFL_CMD_DUAL_OUT_READ || c == `SFL_CMD_DUAL_IO_READ) &&
            i >= `SFL_IDX_DUAL_DATA);
  endfunction

  wire is_dual  = cmd_reg == `SFL_CMD_DUAL_OUT_READ || cmd_reg == `SFL_CMD_DUAL_IO_READ;
  wire dual_in  = cmd_reg == `SFL_CMD_DUAL_IO_READ && idx_reg >= `SFL_IDX_ARG &&
                  idx_reg <= `SFL_IDX_DATA;
  wire dual_w   = dual_in | (is_dual & idx_reg >= `SFL_IDX_DUAL_DATA);
  wire [3:0] cnt_sum = {1'b0, bit_reg} + (dual_w ? 4'h2 : 4'h1);
  wire [7:0] rx_next = dual_w ? {rx_reg[5:0], d1_s, d0_s} : {rx_reg[6:0], d0_s};
  wire byte_end = rise & cnt_sum[3];
  wire [3:0] idx_inc = (idx_reg == `SFL_IDX_MAX) ? idx_reg : idx_reg + 4'h1;
  wire [7:0] cmd_now = (idx_reg == `SFL_IDX_CMD) ? rx_next : cmd_reg;
  wire out_now  = out_phase(cmd_reg, idx_reg);
  wire load_tx  = byte_end & out_phase(cmd_now, idx_inc);
  wire [ADDR_W-1:0] addr_shift = {addr_reg[ADDR_W-9:0], rx_next};
  wire [ADDR_W-1:0] rd_addr = (idx_reg == `SFL_IDX_ADDR_END) ? addr_shift : addr_reg;
  wire [7:0] status_w = {3'h0, bp_reg, wel_reg, busy_w};
  wire [7:0] tx_src = (cmd_now == `SFL_CMD_STATUS_READ) ? status_w : mem[rd_addr];
  wire page_data = byte_end & ~busy_w & cmd_reg == `SFL_CMD_PAGE_WRITE &&
                   idx_reg >= `SFL_IDX_DATA;
  wire page_open = byte_end & ~busy_w & idx_reg == `SFL_IDX_CMD &&
                   rx_next == `SFL_CMD_PAGE_WRITE;
  wire frame_ok = sel_rise & (bit_reg == 3'h0) & ~busy_w;
  wire wr_ok    = frame_ok & wel_reg;
  wire [ADDR_W-1:0] ptr_next = ptr_reg + ADDR_W'(1);
  wire [7:0] old_byte = mem[ptr_reg];
  wire [7:0] new_byte = pvalid_reg[ptr_reg[`SFL_PAGE_BITS-1:0]] ?
                        page_buf[ptr_reg[`SFL_PAGE_BITS-1:0]] : `SFL_ERASED_BYTE;
  wire [7:0] sweep_val = prog_reg ? (old_byte & new_byte) : `SFL_ERASED_BYTE;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      armed_reg <= 1'b0;
      pause_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_s;
      if (sel_d_reg && !sel_s) begin
        armed_reg <= 1'b1;
      end
      if (!sck_s) begin
        pause_reg <= ~hold_s & (pause_reg | ~sel_s);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_reg     <= 3'h0;
      idx_reg     <= `SFL_IDX_CMD;
      cmd_reg     <= 8'h00;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      stw_reg     <= 3'h0;
      addr_reg    <= '0;
      d0_reg      <= 1'b0;
      d1_reg      <= 1'b0;
      oe_reg      <= 1'b0;
      oe_dual_reg <= 1'b0;
    end else if (sel_s) begin
      bit_reg     <= 3'h0;
      idx_reg     <= `SFL_IDX_CMD;
      oe_reg      <= 1'b0;
      oe_dual_reg <= 1'b0;
    end else begin
      if (rise) begin
        rx_reg  <= rx_next;
        bit_reg <= cnt_sum[2:0];
      end
      if (byte_end) begin
        idx_reg <= idx_inc;
        if (idx_reg == `SFL_IDX_CMD) begin
          cmd_reg <= rx_next;
        end
        if (idx_reg >= `SFL_IDX_ARG && idx_reg <= `SFL_IDX_ADDR_END) begin
          addr_reg <= addr_shift;
        end
        if (idx_reg == `SFL_IDX_ARG) begin
          stw_reg <= rx_next[4:2];
        end
      end
      if (page_data) begin
        addr_reg <= {addr_reg[ADDR_W-1:`SFL_PAGE_BITS],
                     addr_reg[`SFL_PAGE_BITS-1:0] + 8'h01};
      end
      if (load_tx) begin
        tx_reg   <= tx_src;
        addr_reg <= rd_addr + ADDR_W'(1);
      end
      if (fall && out_now) begin
        oe_reg <= 1'b1;
        oe_dual_reg <= is_dual;
        if (is_dual) begin
          d1_reg <= tx_reg[7];
          d0_reg <= tx_reg[6];
          tx_reg <= {tx_reg[5:0], 2'b00};
        end else begin
          d1_reg <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  wire drive_ok = ~sel_s & ~pause_reg;
  assign link.dev_d1_o  = d1_reg;
  assign link.dev_d1_oe = oe_reg & drive_ok;
  assign link.dev_d0_o  = d0_reg;
  assign link.dev_d0_oe = oe_dual_reg & drive_ok;

  // The array keeps no reset; a real part powers up holding its old contents.
  always_ff @(posedge ref_clk_i) begin
    if (page_data) begin
      page_buf[addr_reg[`SFL_PAGE_BITS-1:0]] <= rx_next;
    end
    if (left_reg != '0) begin
      mem[ptr_reg] <= sweep_val;
    end
  end

  // busy while timer or sweep runs
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wel_reg    <= 1'b0;
      bp_reg     <= 3'h0;
      timer_reg  <= 32'h0;
      left_reg   <= '0;
      ptr_reg    <= '0;
      prog_reg   <= 1'b0;
      pvalid_reg <= '0;
    end else begin
      if (timer_reg != 32'h0) begin
        timer_reg <= timer_reg - 32'h1;
      end
      if (left_reg != '0) begin
        left_reg <= left_reg - (ADDR_W+1)'(1);
        ptr_reg  <= ptr_next;
        if (prog_reg) begin
          pvalid_reg[ptr_reg[`SFL_PAGE_BITS-1:0]] <= 1'b0;
        end
      end
      if (page_open) begin
        pvalid_reg <= '0;
      end
      if (page_data) begin
        pvalid_reg[addr_reg[`SFL_PAGE_BITS-1:0]] <= 1'b1;
      end
      if (frame_ok) begin
        case (cmd_reg)
          `SFL_CMD_WRITE_LATCH_SET: begin
            if (idx_reg == `SFL_IDX_ARG) wel_reg <= 1'b1;
          end
          `SFL_CMD_WRITE_LATCH_CLR: begin
            if (idx_reg == `SFL_IDX_ARG) wel_reg <= 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (wr_ok) begin
        if (cmd_reg == `SFL_CMD_STATUS_WRITE && idx_reg == `SFL_IDX_ARG + 4'h1) begin
          if (wp_s) bp_reg <= stw_reg;
          wel_reg   <= 1'b0;
          timer_reg <= `SFL_STATUS_WR_CYC;
        end else if (cmd_reg == `SFL_CMD_PAGE_WRITE && idx_reg >= `SFL_IDX_DUAL_DATA) begin
          wel_reg   <= 1'b0;
          prog_reg  <= 1'b1;
          ptr_reg   <= {addr_reg[ADDR_W-1:`SFL_PAGE_BITS], `SFL_PAGE_BITS'(0)};
          left_reg  <= SZ_PAGE;
          timer_reg <= PAGE_CYC;
        end else if (cmd_reg == `SFL_CMD_FOUR_KB_WIPE && idx_reg == `SFL_IDX_DATA) begin
          wel_reg   <= 1'b0;
          prog_reg  <= 1'b0;
          ptr_reg   <= {addr_reg[ADDR_W-1:`SFL_SECTOR_BITS], `SFL_SECTOR_BITS'(0)};
          left_reg  <= SZ_SECT;
          timer_reg <= SECT_CYC;
        end else if (cmd_reg == `SFL_CMD_BLOCK_WIPE && idx_reg == `SFL_IDX_DATA) begin
          wel_reg   <= 1'b0;
          prog_reg  <= 1'b0;
          ptr_reg   <= {addr_reg[ADDR_W-1:`SFL_BLOCK_BITS], `SFL_BLOCK_BITS'(0)};
          left_reg  <= SZ_BLOCK;
          timer_reg <= BLOCK_CYC;
        end else if (cmd_reg == `SFL_CMD_CHIP_WIPE && idx_reg == `SFL_IDX_ARG) begin
          wel_reg   <= 1'b0;
          prog_reg  <= 1'b0;
          ptr_reg   <= '0;
          left_reg  <= SZ_CHIP;
          timer_reg <= CHIP_CYC;
        end
      end
    end
  end

  assign standby_o = sel_s & ~busy_w;
  assign busy_o    = busy_w;
  assign protect_o = bp_reg;
endmodule
`default_nettype wire

/* File: src/sfl_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfl_consts.svh"
module sfl_host #(
  parameter int unsigned HALF = `SFL_HOST_HALF
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Register port.
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Serial link.
  sfl_if.host              link
);
  sfl_pkg::sfl_hst_t st_reg;
  logic [15:0] div_reg;
  logic [2:0]  cfg_reg;
  logic [7:0]  sh_reg;
  logic [2:0]  bit_reg;
  logic        rx_reg;
  logic        dual_reg;
  logic        last_reg;
  logic        sel_n_reg;
  logic        oe_reg;
  logic [7:0]  rxb_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  meta_reg;
  logic [1:0]  sync_reg;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= {link.d1, link.d0};
      sync_reg <= meta_reg;
    end
  end

  wire busy_w  = st_reg != sfl_pkg::SFL_H_IDLE;
  wire xfer_w  = wr_i & (addr_i == `SFL_REG_XFER);
  wire cfg_w   = wr_i & (addr_i == `SFL_REG_CFG);
  wire go      = xfer_w & ~busy_w;
  wire tick    = div_reg == 16'(HALF - 1);
  wire [3:0] cnt_sum = {1'b0, bit_reg} + (dual_reg ? 4'h2 : 4'h1);
  wire [7:0] sh_next = dual_reg ? {sh_reg[5:0], sync_reg[1], sync_reg[0]} :
                                  {sh_reg[6:0], sync_reg[1]};
  wire [31:0] rd_mux = (addr_i == `SFL_REG_XFER) ? {22'h0, ~sel_n_reg, busy_w, rxb_reg} :
                       (addr_i == `SFL_REG_CFG)  ? {29'h0, cfg_reg} : 32'h0;

  // rise mid-bit, fall at bit end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg    <= sfl_pkg::SFL_H_IDLE;
      div_reg   <= 16'h0;
      sh_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      rx_reg    <= 1'b0;
      dual_reg  <= 1'b0;
      last_reg  <= 1'b0;
      sel_n_reg <= 1'b1;
      oe_reg    <= 1'b0;
      rxb_reg   <= 8'h00;
    end else begin
      div_reg <= tick ? 16'h0 : div_reg + 16'h1;
      case (st_reg)
        sfl_pkg::SFL_H_IDLE: begin
          if (go) begin
            // select falls before the first clock
            sel_n_reg <= 1'b0;
            sh_reg    <= wdata_i[7:0];
            rx_reg    <= wdata_i[`SFL_XF_RX];
            dual_reg  <= wdata_i[`SFL_XF_DUAL];
            last_reg  <= wdata_i[`SFL_XF_LAST];
            oe_reg    <= ~wdata_i[`SFL_XF_RX];
            bit_reg   <= 3'h0;
            div_reg   <= 16'h0;
            st_reg    <= sfl_pkg::SFL_H_LOW;
          end
        end
        sfl_pkg::SFL_H_LOW: begin
          if (tick) st_reg <= sfl_pkg::SFL_H_HIGH;
        end
        sfl_pkg::SFL_H_HIGH: begin
          // Sampling at the end of the high half leaves room for the sync delay.
          if (tick) begin
            sh_reg  <= sh_next;
            bit_reg <= cnt_sum[2:0];
            if (cnt_sum[3]) begin
              st_reg  <= sfl_pkg::SFL_H_IDLE;
              oe_reg  <= 1'b0;
              rxb_reg <= sh_next;
              if (last_reg) sel_n_reg <= 1'b1;
            end else begin
              st_reg <= sfl_pkg::SFL_H_LOW;
            end
          end
        end
        default: st_reg <= sfl_pkg::SFL_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_reg   <= `SFL_CFG_RESET;
      rdata_reg <= 32'h0;
    end else begin
      if (cfg_w) cfg_reg <= wdata_i[2:0];
      rdata_reg <= rd_i ? rd_mux : 32'h0;
    end
  end

  // idle clock parks at mode level
  assign link.sclk       = (st_reg == sfl_pkg::SFL_H_HIGH) |
                           (~busy_w & cfg_reg[`SFL_CFG_CPOL]);
  assign link.sel_n      = sel_n_reg;
  assign link.hold_n     = cfg_reg[`SFL_CFG_HOLD] | sel_n_reg;
  assign link.wp_n       = cfg_reg[`SFL_CFG_WP];
  // both lines drive in dual send
  assign link.host_d0_o  = dual_reg ? sh_reg[6] : sh_reg[7];
  assign link.host_d0_oe = oe_reg;
  assign link.host_d1_o  = sh_reg[7];
  assign link.host_d1_oe = oe_reg & dual_reg;
  assign rdata_o         = rdata_reg;
endmodule
`default_nettype wire

/* File: verification/sfl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module sfl_assertions (
  // Clock and reset.
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  // Link signals.
  input wire logic       sel_n,
  input wire logic       sclk,
  input wire logic       hold_n,
  input wire logic       wp_n,
  input wire logic       host_d0_o,
  input wire logic       host_d0_oe,
  input wire logic       dev_d0_oe,
  input wire logic       dev_d1_o,
  input wire logic       dev_d1_oe,
  // Device status.
  input wire logic       busy_o,
  input wire logic       standby_o,
  input wire logic [2:0] protect_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // Bounds every internal cycle without an unbounded eventuality.
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  assign busy_cnt_next = busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  sequence s_sclk_high;
    sclk [*3];
  endsequence
  sequence s_wp_low;
    !wp_n [*4];
  endsequence

  property p_desel_release;
    sel_n [*6] |-> !dev_d0_oe && !dev_d1_oe;
  endproperty
  property p_hold_release;
    !hold_n [*6] |-> !dev_d0_oe && !dev_d1_oe;
  endproperty
  property p_dev_launch;
    (s_sclk_high and dev_d1_oe [*3]) |-> $stable(dev_d1_o);
  endproperty
  property p_host_launch;
    (s_sclk_high and host_d0_oe [*3]) |-> $stable(host_d0_o);
  endproperty
  property p_busy_standby;
    sel_n [*3] |-> standby_o == !busy_o;
  endproperty
  property p_sel_standby;
    !sel_n [*5] |-> !standby_o;
  endproperty
  property p_busy_bound;
    busy_o |-> busy_cnt_reg < 16'h2000;
  endproperty
  property p_wp_freeze;
    s_wp_low |-> $stable(protect_o);
  endproperty
  property p_dual_pair;
    dev_d0_oe |-> dev_d1_oe;
  endproperty

  a_desel_release: assert property (p_desel_release)
    else $error("Device drives the link while deselected.");
  a_hold_release: assert property (p_hold_release)
    else $error("Device drives the link while paused.");
  a_dev_launch: assert property (p_dev_launch)
    else $error("Device output changed while serial clock high.");
  a_host_launch: assert property (p_host_launch)
    else $error("Host data changed while serial clock high.");
  a_busy_standby: assert property (p_busy_standby)
    else $error("Standby does not follow select and busy.");
  a_sel_standby: assert property (p_sel_standby)
    else $error("Standby reported while selected.");
  a_busy_bound: assert property (p_busy_bound)
    else $error("Internal cycle runs too long.");
  a_wp_freeze: assert property (p_wp_freeze)
    else $error("Protect levels changed while write protect low.");
  a_dual_pair: assert property (p_dual_pair)
    else $error("Input line driven outside a dual read.");
endmodule
`default_nettype wire

/* File: verification/tb_spi_serial_flash_interface.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfl_consts.svh"
module tb_spi_serial_flash_interface;
  logic        ref_clk_i;
  logic        reset_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        busy_o;
  logic        standby_o;
  logic [2:0]  protect_o;
  int          failures;
  int          checks_done;
  logic [31:0] rnd;
  logic [7:0]  pg [256];
  logic [17:0] base;
  logic [7:0]  s;
  logic [31:0] d;

  sfl_if link ();
  sfl_host sfl_host_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  sfl_device #(.PAGE_CYC(300), .SECT_CYC(300), .BLOCK_CYC(300), .CHIP_CYC(300)) sfl_device_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link), .busy_o(busy_o),
    .standby_o(standby_o), .protect_o(protect_o));
  sfl_assertions sfl_assertions_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .sel_n(link.sel_n), .sclk(link.sclk), .hold_n(link.hold_n), .wp_n(link.wp_n),
    .host_d0_o(link.host_d0_o), .host_d0_oe(link.host_d0_oe), .dev_d0_oe(link.dev_d0_oe),
    .dev_d1_o(link.dev_d1_o), .dev_d1_oe(link.dev_d1_oe), .busy_o(busy_o),
    .standby_o(standby_o), .protect_o(protect_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  // Control word: [10] last byte, [9] dual, [8] receive, [7:0] byte.
  task automatic xfer(input logic [10:0] ctl, output logic [7:0] rx);
    logic [31:0] v;
    int n;
    wr(`SFL_REG_XFER, {21'h0, ctl});
    n = 0;
    do begin
      rd(`SFL_REG_XFER, v);
      n++;
    end while (v[8] !== 1'b0 && n < 200);
    check("xfer_done", 32'(v[8]), 32'h0);
    rx = v[7:0];
  endtask

  task automatic send(input logic [7:0] v, input logic last);
    logic [7:0] x;
    xfer({last, 2'b00, v}, x);
  endtask

  task automatic cmd_addr(input logic [7:0] c, input logic [17:0] a, input logic last);
    send(c, 1'b0);
    send({6'h0, a[17:16]}, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], last);
  endtask

  task automatic latch_set;
    send(`SFL_CMD_WRITE_LATCH_SET, 1'b1);
  endtask

  task automatic status(output logic [7:0] v);
    send(`SFL_CMD_STATUS_READ, 1'b0);
    xfer(11'h500, v);
  endtask

  task automatic wait_idle;
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      status(v);
      n++;
    end while (v[0] !== 1'b0 && n < 100);
    check("idle", 32'(v[0]), 32'h0);
    check("latch_clear", 32'(v[1]), 32'h0);
  endtask

  // Programs n random bytes from base; without the latch nothing may change.
  task automatic page_prog(input logic arm, input int n);
    logic [7:0] ix;
    if (arm) latch_set;
    cmd_addr(`SFL_CMD_PAGE_WRITE, base, 1'b0);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      ix = base[7:0] + 8'(i);
      send(rnd[7:0], i == n - 1);
      if (arm) pg[ix] = pg[ix] & rnd[7:0];
    end
    wait_idle;
  endtask

  // Mode m: [0] header in dual, [1] data in dual; a dummy byte follows the
  // address for the fast reads.
  task automatic read_cmp(input logic [7:0] c, input logic [1:0] m, input logic [17:0] a,
                          input int n);
    logic [7:0]  x;
    logic [31:0] h;
    h = {6'h0, a, 8'h00};
    send(c, 1'b0);
    for (int i = 0; i < ((c == `SFL_CMD_READ) ? 3 : 4); i++)
      xfer({1'b0, m[0], 1'b0, h[31-8*i -: 8]}, x);
    for (int i = 0; i < n; i++) begin
      xfer({i == n - 1, m[1], 1'b1, 8'h00}, x);
      check("read", 32'(x), 32'(pg[a[7:0] + 8'(i)]));
    end
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk_i);
    failures++;
    summarize;
  end

  initial begin
    reset_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    failures = 0;
    checks_done = 0;
    rnd = 32'h2B17E21F;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd(`SFL_REG_CFG, d);
    check("cfg", d, 32'h6);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, d);
    check("unmapped", d, 32'h0);
    check("standby", 32'(standby_o), 32'h1);
    status(s);
    check("status", 32'(s), 32'h0);
    rnd = lfsr(rnd);
    base = {rnd[5:0], rnd[11:8], 8'hF0};
    latch_set;
    status(s);
    check("latch", 32'(s), 32'h2);
    cmd_addr(`SFL_CMD_FOUR_KB_WIPE, base, 1'b1);
    repeat (8) @(posedge ref_clk_i);
    check("busy", 32'(busy_o), 32'h1);
    check("standby_busy", 32'(standby_o), 32'h0);
    wait_idle;
    for (int i = 0; i < 256; i++) pg[i] = 8'hFF;
    page_prog(1'b1, 256);
    read_cmp(`SFL_CMD_DUAL_OUT_READ, 2'b10, {base[17:8], 8'h00}, 256);
    page_prog(1'b0, 4);
    base[7:0] = 8'hFC;
    page_prog(1'b1, 8);
    read_cmp(`SFL_CMD_READ, 2'b00, {base[17:8], 8'hF0}, 16);
    wr(`SFL_REG_CFG, 32'h7);
    repeat (4) @(posedge ref_clk_i);
    check("idle_clk", 32'(link.sclk), 32'h1);
    read_cmp(`SFL_CMD_DUAL_IO_READ, 2'b11, {base[17:8], 8'hF0}, 16);
    wr(`SFL_REG_CFG, 32'h6);
    for (int k = 0; k < 3; k++) begin
      wr(`SFL_REG_CFG, (k == 0) ? 32'h2 : 32'h6);
      latch_set;
      send(`SFL_CMD_STATUS_WRITE, 1'b0);
      send((k == 2) ? 8'h00 : 8'h1C, 1'b1);
      wait_idle;
      check("protect", 32'(protect_o), (k == 1) ? 32'h7 : 32'h0);
    end
    send(`SFL_CMD_STATUS_READ, 1'b0);
    wr(`SFL_REG_CFG, 32'h4);
    repeat (20) @(posedge ref_clk_i);
    // Clocks sent while paused must be ignored and the line left to its pull-up.
    xfer(11'h100, s);
    check("hold_float", 32'(s), 32'hFF);
    wr(`SFL_REG_CFG, 32'h6);
    xfer(11'h500, s);
    check("hold_resume", 32'(s), 32'h0);
    latch_set;
    send(`SFL_CMD_WRITE_LATCH_CLR, 1'b1);
    status(s);
    check("latch_clr", 32'(s), 32'h0);
    cmd_addr(`SFL_CMD_BLOCK_WIPE, base, 1'b1);
    send(`SFL_CMD_CHIP_WIPE, 1'b1);
    status(s);
    check("wipe_refused", 32'(s), 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
